// ---- hw/aisc_pkg.sv ----
// Constants, register map and field layout of the analog input scan control.
package aisc_pkg;

  // ************************************************************
  // Clock and pacing
  // ************************************************************
  localparam int CLK_KHZ         = 20000;
  localparam int CONV_SINGLE_KSPS = 1500;
  localparam int CONV_MULTI_KSPS  = 1000;
  // Highest rates are shortest intervals, so the division rounds down.
  localparam logic [4:0] CONV_SINGLE_CYC = 5'(CLK_KHZ / CONV_SINGLE_KSPS);
  localparam logic [4:0] CONV_MULTI_CYC  = 5'(CLK_KHZ / CONV_MULTI_KSPS);
  localparam logic [2:0] SYNC_OUT_CYC    = 3'h4;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_RATE_A = 5'h04;
  localparam logic [4:0] OFS_RATE_B = 5'h08;
  localparam logic [4:0] OFS_THRESH = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_DATA   = 5'h14;

  // ************************************************************
  // Control register fields
  // ************************************************************
  localparam int B_EN      = 0;
  localparam int B_DIFF    = 1;
  localparam int B_MODE    = 2;   // two bits
  localparam int B_SIZE    = 4;   // two bits
  localparam int B_CONT    = 6;
  localparam int B_SRC     = 7;   // two bits
  localparam int B_RANGE   = 9;   // two bits
  localparam int B_STEST   = 11;
  localparam int B_LOOP    = 12;
  localparam int B_CHSEL   = 13;  // five bits
  localparam int B_SWSYNC  = 18;
  localparam int B_FCLR    = 19;
  localparam int B_IE_THR  = 20;
  localparam int B_IE_DONE = 21;
  localparam int B_DMA_EN  = 22;
  localparam logic [31:0] CTRL_MASK  = 32'h0073_FFFF;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Status register fields.
  localparam int B_THR  = 16;
  localparam int B_BUSY = 17;
  localparam int B_OVF  = 18;
  localparam int B_DONE = 19;

  // Mode, size, clock source and range codes.
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_TWO    = 2'h1;
  localparam logic [1:0] MODE_MULTI  = 2'h2;
  localparam logic [1:0] SIZE_16     = 2'h2;
  localparam logic [1:0] SIZE_32     = 2'h3;
  localparam logic [1:0] SRC_GEN_A   = 2'h0;
  localparam logic [1:0] SRC_CASCADE = 2'h1;
  localparam logic [1:0] SRC_OUT_CLK = 2'h2;
  localparam logic [1:0] SRC_SYNC    = 2'h3;
  localparam logic [1:0] RANGE_BAD   = 2'h3;

  localparam logic [15:0] RATE_RESET   = 16'hFFFF;
  localparam logic [14:0] THRESH_RESET = 15'h4000;
  localparam logic [14:0] THRESH_MAX   = 15'h7FFE;

endpackage : aisc_pkg

// ---- hw/aisc_fifo.sv ----
// Sample buffer for converted input codes, flip-flop storage.
`timescale 1ns/1ps
module aisc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32768,
  parameter int CW    = $clog2(DEPTH) + 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             clr_i,
  input  wire logic             push_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic             pop_i,
  output logic      [WIDTH-1:0] rdata_o,
  output logic      [CW-1:0]    count_o,
  output logic                  full_o,
  output logic                  empty_o
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("aisc_fifo: DEPTH must be a power of two");
    end
  end

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] cnt;
  } aisc_fifo_st_t;

  aisc_fifo_st_t    s;
  aisc_fifo_st_t    next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             do_push;
  logic             do_pop;

  assign full_o  = (s.cnt == CW'(DEPTH));
  assign empty_o = (s.cnt == '0);
  assign count_o = s.cnt;
  assign rdata_o = mem[s.rd];
  assign do_push = push_i && !full_o;
  assign do_pop  = pop_i && !empty_o;

  // Pointer and count update; a full buffer drops the pushed sample.
  always_comb begin
    next_s = s;
    if (do_push) begin
      next_s.wr = s.wr + AW'(1);
    end
    if (do_pop) begin
      next_s.rd = s.rd + AW'(1);
    end
    next_s.cnt = s.cnt + CW'(do_push) - CW'(do_pop);
    if (clr_i) begin
      next_s = '0;
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Storage is written only, never reset, to keep it plain flip-flops.
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[s.wr] <= wdata_i;
    end
  end

endmodule : aisc_fifo

// ---- hw/aisc_top.sv ----
// Analog input scan control: register slave, pacing, scan engine, buffer.
// Operation
// - Inputs single-ended thirty-two or differential sixteen.
// - Scan sizes two, four, eight, sixteen, thirty-two.
// - Thirty-two channel scan only single-ended.
// - Scan rate is conversion rate over channels.
// - One sync gives one back-to-back scan.
// - Sync output can start up to three targets.
// - Continuous mode repeats scans at scan rate.
// - Single-channel mode converts one channel repeatedly.
// - Conversion pacing 1500K single, 1000K multi.
// - Scan rate 250K multi, 500K two-channel.
// - Lowest rate one generator, lower cascaded.
// - Sync-triggered scans have no minimum rate.
// - Pacing from output sample clock selectable.
// - External sync in, hardware sync out.
// - Sample buffer with programmable threshold, DMA.
// - Interrupt on selected conditions incl buffer.
// - Each sample is a 12-bit code.
// - One range field for all channels.
// - Selftest routes reference or loopback in.
// - DMA request and one shared interrupt line.
//
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
module aisc_top #(
  parameter int DEPTH = 32768,
  parameter int CW    = $clog2(DEPTH) + 1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sync_i,
  input  wire logic        out_clk_i,
  input  wire logic        adc_done_i,
  input  wire logic [11:0] adc_data_i,
  output logic             adc_start_o,
  output logic      [4:0]  adc_chan_o,
  output logic             diff_o,
  output logic      [1:0]  range_o,
  output logic             selftest_o,
  output logic             loop_o,
  output logic             sync_o,
  output logic             dma_req_o,
  output logic             irq_o
);

  initial begin
    if (DEPTH > 32768 || CW > 16) begin
      $error("aisc_top: DEPTH above 32768 does not fit the status word");
    end
  end

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Channels per scan for a mode and size code.
  function automatic logic [5:0] nchan(input logic [1:0] mode,
                                       input logic [1:0] size);
    logic [5:0] r;
    r = 6'h01;
    if (mode == aisc_pkg::MODE_TWO) begin
      r = 6'h02;
    end else if (mode == aisc_pkg::MODE_MULTI) begin
      r = 6'h04 << size;
    end
    return r;
  endfunction : nchan

  // Byte-lane merge of a write into an old register value.
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] rate_a;
    logic [15:0] rate_b;
    logic [14:0] thresh;
    logic        ovf;
    logic        done;
    logic [15:0] cnt_a;
    logic [15:0] cnt_b;
    logic [2:0]  sync_sh;
    logic        sync_st;
    logic        busy;
    logic [5:0]  idx;
    logic [4:0]  timer;
    logic [2:0]  so_cnt;
    logic        thr;
    logic        adc_start;
    logic [4:0]  adc_chan;
    logic        sync_out;
    logic        dma_req;
    logic        irq;
    logic        ack;
    logic [31:0] dat;
  } aisc_st_t;

  aisc_st_t    s;
  aisc_st_t    next_s;
  logic        fclr;
  logic        pop;
  logic        tick_a;
  logic        tick_b;
  logic        pace;
  logic        trig;
  logic        ext_rise;
  logic        sw_sync;
  logic [5:0]  nch;
  logic [4:0]  chan;
  logic [31:0] newc;
  logic [11:0] f_rdata;
  logic [CW-1:0] f_count;
  logic        f_full;
  logic        f_empty;

  // Sample buffer; a sample is the bare 12-bit converter code.
  aisc_fifo #(.WIDTH(12), .DEPTH(DEPTH), .CW(CW)) u_fifo (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clr_i   (fclr),
    .push_i  (adc_done_i),
    .wdata_i (adc_data_i),
    .pop_i   (pop),
    .rdata_o (f_rdata),
    .count_o (f_count),
    .full_o  (f_full),
    .empty_o (f_empty)
  );

  // ************************************************************
  // Next-state logic
  // ************************************************************

  // Bus slave, pacing, scan engine and status, in one pass.
  always_comb begin
    next_s    = s;
    fclr      = 1'b0;
    pop       = 1'b0;
    sw_sync   = 1'b0;
    tick_a    = 1'b0;
    tick_b    = 1'b0;
    pace      = 1'b0;
    trig      = 1'b0;
    ext_rise  = 1'b0;
    newc      = s.ctrl;
    chan      = '0;
    nch       = nchan(s.ctrl[aisc_pkg::B_MODE +: 2],
                      s.ctrl[aisc_pkg::B_SIZE +: 2]);
    next_s.adc_start = 1'b0;
    next_s.ack       = 1'b0;

    // Classic cycle: answer one cycle after the request, for one cycle.
    if (wb_cyc_i && wb_stb_i && !s.ack) begin
      next_s.ack = 1'b1;
      next_s.dat = '0;
      if (wb_we_i) begin
        unique case (wb_adr_i)
          aisc_pkg::OFS_CTRL: begin
            newc    = wmerge(s.ctrl, wb_dat_i, wb_sel_i);
            sw_sync = newc[aisc_pkg::B_SWSYNC];
            fclr    = newc[aisc_pkg::B_FCLR];
            if (newc[aisc_pkg::B_DIFF] &&
                newc[aisc_pkg::B_SIZE +: 2] == aisc_pkg::SIZE_32) begin
              newc[aisc_pkg::B_SIZE +: 2] = aisc_pkg::SIZE_16;
            end
            if (newc[aisc_pkg::B_RANGE +: 2] == aisc_pkg::RANGE_BAD) begin
              newc[aisc_pkg::B_RANGE +: 2] =
                s.ctrl[aisc_pkg::B_RANGE +: 2];
            end
            next_s.ctrl = newc & aisc_pkg::CTRL_MASK;
          end
          aisc_pkg::OFS_RATE_A: begin
            next_s.rate_a = 16'(wmerge({16'h0000, s.rate_a}, wb_dat_i,
                                       wb_sel_i));
          end
          aisc_pkg::OFS_RATE_B: begin
            next_s.rate_b = 16'(wmerge({16'h0000, s.rate_b}, wb_dat_i,
                                       wb_sel_i));
          end
          aisc_pkg::OFS_THRESH: begin
            next_s.thresh = 15'(wmerge({17'h0, s.thresh}, wb_dat_i,
                                       wb_sel_i));
            if (next_s.thresh > aisc_pkg::THRESH_MAX) begin
              next_s.thresh = aisc_pkg::THRESH_MAX;
            end
          end
          aisc_pkg::OFS_STATUS: begin
            // Write one to clear; a new event below still wins.
            if (wb_sel_i[2] && wb_dat_i[aisc_pkg::B_OVF]) begin
              next_s.ovf = 1'b0;
            end
            if (wb_sel_i[2] && wb_dat_i[aisc_pkg::B_DONE]) begin
              next_s.done = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end else begin
        unique case (wb_adr_i)
          aisc_pkg::OFS_CTRL:   next_s.dat = s.ctrl;
          aisc_pkg::OFS_RATE_A: next_s.dat = {16'h0000, s.rate_a};
          aisc_pkg::OFS_RATE_B: next_s.dat = {16'h0000, s.rate_b};
          aisc_pkg::OFS_THRESH: next_s.dat = {17'h0, s.thresh};
          aisc_pkg::OFS_STATUS: begin
            next_s.dat = {12'h000, s.done, s.ovf, s.busy, s.thr,
                          16'(f_count)};
          end
          aisc_pkg::OFS_DATA: begin
            // Reading the data word takes the oldest sample out.
            next_s.dat = {20'h00000, f_empty ? 12'h000 : f_rdata};
            pop        = !f_empty;
          end
          default: next_s.dat = '0;
        endcase
      end
    end

    // Rate generators; the second counts ticks of the first.
    if (s.cnt_a == '0) begin
      tick_a       = 1'b1;
      next_s.cnt_a = s.rate_a;
    end else if (s.cnt_a > s.rate_a) begin
      // A lowered rate takes hold at once, not after the old long count.
      next_s.cnt_a = s.rate_a;
    end else begin
      next_s.cnt_a = s.cnt_a - 16'h0001;
    end
    if (tick_a) begin
      if (s.cnt_b == '0) begin
        tick_b       = 1'b1;
        next_s.cnt_b = s.rate_b;
      end else if (s.cnt_b > s.rate_b) begin
        next_s.cnt_b = s.rate_b;
      end else begin
        next_s.cnt_b = s.cnt_b - 16'h0001;
      end
    end

    // External sync: the second and third stages must agree first.
    next_s.sync_sh = {s.sync_sh[1:0], sync_i};
    if (s.sync_sh[1] == s.sync_sh[2] && s.sync_sh[2] != s.sync_st) begin
      next_s.sync_st = s.sync_sh[2];
      ext_rise       = s.sync_sh[2];
    end

    // Scan pacing source.
    unique case (s.ctrl[aisc_pkg::B_SRC +: 2])
      aisc_pkg::SRC_GEN_A:   pace = tick_a;
      aisc_pkg::SRC_CASCADE: pace = tick_b;
      aisc_pkg::SRC_OUT_CLK: pace = out_clk_i;
      aisc_pkg::SRC_SYNC:    pace = sw_sync || ext_rise;
    endcase
    if (s.ctrl[aisc_pkg::B_MODE +: 2] == aisc_pkg::MODE_SINGLE &&
        s.ctrl[aisc_pkg::B_CONT]) begin
      trig = 1'b1;
    end else if (s.ctrl[aisc_pkg::B_CONT]) begin
      trig = pace;
    end else begin
      trig = sw_sync || ext_rise;
    end

    // Channel of the next conversion.
    if (s.ctrl[aisc_pkg::B_MODE +: 2] == aisc_pkg::MODE_SINGLE) begin
      chan = s.ctrl[aisc_pkg::B_CHSEL +: 5];
      if (s.ctrl[aisc_pkg::B_DIFF]) begin
        chan[4] = 1'b0;
      end
    end else begin
      chan = s.idx[4:0];
    end

    // Scan engine: conversions spaced by the converter interval.
    if (s.timer != '0) begin
      next_s.timer = s.timer - 5'h01;
    end
    if (s.so_cnt != '0) begin
      next_s.so_cnt = s.so_cnt - 3'h1;
    end
    if (!s.ctrl[aisc_pkg::B_EN]) begin
      next_s.busy = 1'b0;
      next_s.idx  = '0;
    end else if (s.timer == '0 && (s.busy || trig)) begin
      next_s.adc_start = 1'b1;
      next_s.adc_chan  = chan;
      next_s.timer = (s.ctrl[aisc_pkg::B_MODE +: 2] ==
                      aisc_pkg::MODE_SINGLE)
                     ? aisc_pkg::CONV_SINGLE_CYC - 5'h01
                     : aisc_pkg::CONV_MULTI_CYC - 5'h01;
      if (!s.busy) begin
        next_s.so_cnt = aisc_pkg::SYNC_OUT_CYC;
      end
      if (s.idx + 6'h01 >= nch) begin
        next_s.busy = 1'b0;
        next_s.idx  = '0;
        next_s.done = 1'b1;
      end else begin
        next_s.busy = 1'b1;
        next_s.idx  = s.idx + 6'h01;
      end
    end

    // Sync output is stretched so targets with slow sampling see it.
    next_s.sync_out = (next_s.so_cnt != '0);

    // Buffer level, overflow, DMA and interrupt.
    if (adc_done_i && f_full) begin
      next_s.ovf = 1'b1;
    end
    next_s.thr     = (16'(f_count) > {1'b0, s.thresh});
    next_s.dma_req = s.thr && s.ctrl[aisc_pkg::B_DMA_EN];
    next_s.irq     = (s.thr && s.ctrl[aisc_pkg::B_IE_THR]) ||
                     (s.done && s.ctrl[aisc_pkg::B_IE_DONE]);
  end

  // ************************************************************
  // State register
  // ************************************************************

  // Every field restarts from a constant.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s        <= '0;
      s.ctrl   <= aisc_pkg::CTRL_RESET;
      s.rate_a <= aisc_pkg::RATE_RESET;
      s.rate_b <= aisc_pkg::RATE_RESET;
      s.thresh <= aisc_pkg::THRESH_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state register.
  assign wb_dat_o    = s.dat;
  assign wb_ack_o    = s.ack;
  assign adc_start_o = s.adc_start;
  assign adc_chan_o  = s.adc_chan;
  assign diff_o      = s.ctrl[aisc_pkg::B_DIFF];
  assign range_o     = s.ctrl[aisc_pkg::B_RANGE +: 2];
  assign selftest_o  = s.ctrl[aisc_pkg::B_STEST];
  assign loop_o      = s.ctrl[aisc_pkg::B_LOOP];
  assign sync_o      = s.sync_out;
  assign dma_req_o   = s.dma_req;
  assign irq_o       = s.irq;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_once_a: assert property (s.ack |=> !s.ack)
    else $error("ack held longer than one cycle");
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !s.ack |=> s.ack)
    else $error("request not answered in one cycle");
  diff_size_a: assert property (
    s.ctrl[aisc_pkg::B_DIFF] |->
      s.ctrl[aisc_pkg::B_SIZE +: 2] != aisc_pkg::SIZE_32)
    else $error("thirty-two channel scan in differential mode");
  conv_gap_a: assert property (s.adc_start |=> !s.adc_start [*8])
    else $error("conversions closer than the converter interval");
  idx_hold_a: assert property (
    s.busy && s.timer != '0 && s.ctrl[aisc_pkg::B_EN] |=>
      s.idx == $past(s.idx))
    else $error("scan index moved between conversions");
  thr_flag_a: assert property (
    ##1 s.thr == $past(16'(f_count) > {1'b0, s.thresh}))
    else $error("threshold flag does not follow the count");
  single_ch_a: assert property (
    s.adc_start && s.ctrl[aisc_pkg::B_MODE +: 2] == aisc_pkg::MODE_SINGLE
      && $stable(s.ctrl) |->
      s.adc_chan[3:0] == s.ctrl[aisc_pkg::B_CHSEL +: 4])
    else $error("single-channel mode converted another channel");
  sync_out_a: assert property ($rose(s.sync_out) |-> s.adc_start)
    else $error("sync output without a scan start");
  range_ok_a: assert property (
    s.ctrl[aisc_pkg::B_RANGE +: 2] != aisc_pkg::RANGE_BAD)
    else $error("reserved range code stored");
  scan_len_a: assert property (
    s.adc_start |-> s.idx < nch || s.idx == '0)
    else $error("scan index beyond the scan size");

  burst_c: cover property (!s.ctrl[aisc_pkg::B_CONT] && s.done && s.ack);
  ovf_c:   cover property (adc_done_i && f_full);
  diff_c:  cover property (s.busy && s.ctrl[aisc_pkg::B_DIFF]);
  thr_c:   cover property ($rose(s.thr));

endmodule : aisc_top

// ---- dv/aisc_adc_model.sv ----
// Behavioural converter model answering start pulses with coded samples.
`timescale 1ns/1ps
module aisc_adc_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic        slow_i,
  input  wire logic [4:0]  chan_i,
  output logic             done_o,
  output logic      [11:0] data_o
);
  logic       busy;
  logic [3:0] cnt;
  logic [4:0] ch;

  // ************************************************************
  // Conversion timing
  // ************************************************************
  // Data flips outside the result cycle, so a stale code never passes.
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    data_o <= ~data_o;
    if (rst_i) begin
      busy   <= 1'b0;
      cnt    <= 4'h0;
      ch     <= 5'h00;
      data_o <= 12'h000;
    end else if (start_i) begin
      busy <= 1'b1;
      ch   <= chan_i;
      cnt  <= slow_i ? 4'hA : 4'h1;
    end else if (busy && cnt == 4'h0) begin
      busy   <= 1'b0;
      done_o <= 1'b1;
      data_o <= {7'h53, ch};
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule : aisc_adc_model

// ---- dv/test_aisc_top.sv ----
// Self-checking bench for the analog input scan control.
`timescale 1ns/1ps
`define CHK(a, b, m) begin cmp_count++; \
  if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED at %0t: %s", $time, m); end end
module test_aisc_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        sync_i = 1'b0, out_clk = 1'b0, slow = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wd = 32'h0, rdo, rdat;
  logic        ack, start, done, diff_o, selftest_o, loop_o;
  logic        sync_o, dma_req_o, irq_o;
  logic [4:0]  chan;
  logic [11:0] code;
  logic [1:0]  range_o;
  int          err_total = 0, cmp_count = 0, cyc_n = 0, n_sync = 0;
  int          st_t[$];
  logic [4:0]  st_c[$];

  always #25 clk_i = ~clk_i;

  aisc_top #(.DEPTH(16)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdo), .wb_ack_o(ack),
    .sync_i(sync_i), .out_clk_i(out_clk), .adc_done_i(done),
    .adc_data_i(code), .adc_start_o(start), .adc_chan_o(chan),
    .diff_o(diff_o), .range_o(range_o), .selftest_o(selftest_o),
    .loop_o(loop_o), .sync_o(sync_o), .dma_req_o(dma_req_o),
    .irq_o(irq_o));

  aisc_adc_model adc (.clk_i(clk_i), .rst_i(rst_i), .start_i(start),
    .slow_i(slow), .chan_i(chan), .done_o(done), .data_o(code));

  // ************************************************************
  // Monitor and timeout
  // ************************************************************
  // Log each start; sampled before the edge's own updates land.
  always @(posedge clk_i) begin
    cyc_n++;
    if (sync_o === 1'b1) n_sync++;
    if (start === 1'b1) begin
      st_t.push_back(cyc_n);
      st_c.push_back(chan);
    end
    if (cyc_n > 20000) begin
      err_total++;
      final_report();
    end
  end

  // One classic cycle; held until ack is sampled, then idle a cycle.
  // A hung slave is ended by the cycle ceiling of the monitor.
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    wd  <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdat = rdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  // Poll busy, then let the last result land and read status.
  task automatic idle();
    int n;
    n = 0;
    repeat (8) @(posedge clk_i);
    do begin
      bus(1'b0, 5'h10, 32'h0);
      n++;
    end while (rdat[17] !== 1'b0 && n < 100);
    repeat (16) @(posedge clk_i);
    bus(1'b0, 5'h10, 32'h0);
  endtask : idle

  task automatic chk_seq(input int cnt, input logic [4:0] c0,
                         input logic [4:0] step, input int gap);
    for (int i = 0; i < cnt; i++) begin
      `CHK(st_c[i], 5'(c0 + step * i), "channel order")
      if (i > 0) `CHK(st_t[i] - st_t[i-1], gap, "spacing")
    end
    st_t.delete();
    st_c.delete();
  endtask : chk_seq

  task final_report();
    if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, 5'h04, 32'h0);
    `CHK(rdat, 32'h0000_FFFF, "rate reset")
    bus(1'b0, 5'h18, 32'h0);
    `CHK(rdat, 32'h0, "unmapped read")
    bus(1'b1, 5'h0C, 32'h0000_7FFF);
    bus(1'b0, 5'h0C, 32'h0);
    `CHK(rdat, 32'h0000_7FFE, "threshold cap")
    bus(1'b1, 5'h00, 32'h0000_1A32);
    bus(1'b0, 5'h00, 32'h0);
    `CHK(rdat[5:4], 2'h2, "diff size")
    `CHK(diff_o, 1'b1, "diff out")
    `CHK({selftest_o, loop_o}, 2'h3, "selftest")
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, 5'h00, 32'(r) << 9);
      `CHK(range_o, 2'(r == 3 ? 2 : r), "range")
    end
    // Burst of four, retriggered mid-scan, threshold two.
    bus(1'b1, 5'h0C, 32'h2);
    n_sync = 0;
    bus(1'b1, 5'h00, 32'h0054_0189);
    bus(1'b1, 5'h00, 32'h0054_0189);
    bus(1'b1, 5'h00, 32'h0054_0189);
    idle();
    `CHK(st_c.size(), 4, "burst count")
    chk_seq(4, 5'h00, 5'h01, 20);
    `CHK(n_sync, 4, "sync out")
    `CHK(rdat[16:0], 17'h1_0004, "count thr")
    `CHK({dma_req_o, irq_o}, 2'h3, "dma irq")
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 5'h14, 32'h0);
      `CHK(rdat[11:0], {7'h53, 5'(i)}, "sample")
    end
    bus(1'b0, 5'h10, 32'h0);
    `CHK(rdat[16], 1'b0, "thr low")
    // Two-channel scan on the sync pin, slow converter.
    slow <= 1'b1;
    bus(1'b1, 5'h00, 32'h0000_0185);
    repeat (200) @(posedge clk_i);
    `CHK(st_c.size(), 0, "no trigger")
    sync_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    sync_i <= 1'b0;
    idle();
    `CHK(st_c.size(), 2, "two ch")
    chk_seq(2, 5'h00, 5'h01, 20);
    // One output clock tick gives one scan.
    bus(1'b1, 5'h00, 32'h0000_0149);
    out_clk <= 1'b1;
    @(posedge clk_i);
    out_clk <= 1'b0;
    idle();
    `CHK(st_c.size(), 4, "out clk")
    chk_seq(4, 5'h00, 5'h01, 20);
    // Continuous scans paced by generator A every 100 cycles.
    bus(1'b1, 5'h04, 32'h63);
    bus(1'b1, 5'h00, 32'h0000_0049);
    repeat (700) @(posedge clk_i);
    bus(1'b1, 5'h00, 32'h0);
    `CHK(st_t[4] - st_t[0], 100, "scan pace")
    `CHK(st_t[8] - st_t[4], 100, "scan pace")
    chk_seq(4, 5'h00, 5'h01, 20);
    // Cascade: generator B passes every second tick of A.
    bus(1'b1, 5'h08, 32'h1);
    bus(1'b1, 5'h00, 32'h0000_00C9);
    repeat (700) @(posedge clk_i);
    bus(1'b1, 5'h00, 32'h0);
    `CHK(st_t[4] - st_t[0], 200, "cascade pace")
    chk_seq(4, 5'h00, 5'h01, 20);
    // Single channel five, continuous at the fast pace.
    bus(1'b1, 5'h00, 32'h0004_A041);
    repeat (200) @(posedge clk_i);
    bus(1'b1, 5'h00, 32'h0);
    chk_seq(10, 5'h05, 5'h00, 13);
    // The long runs overfilled the buffer; clear it and the flags.
    idle();
    `CHK(rdat[18], 1'b1, "overflow")
    `CHK(rdat[15:0], 16'h0010, "full count")
    bus(1'b1, 5'h00, 32'h0008_0000);
    bus(1'b1, 5'h10, 32'h000C_0000);
    bus(1'b0, 5'h10, 32'h0);
    `CHK(rdat[19:0], 20'h0, "cleared")
    final_report();
  end
endmodule : test_aisc_top
